// *** core/grs_remote_ctrl.sv ***
// remote/local, lockout, addressing and service request control with ahb-lite registers
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "grs_consts.svh"
// What this block does
// - remote only on listen address with ren
// - entering remote forces free-run trigger only
// - remote and addressed indicators driven separately
// - gtl while listening leaves remote, keeps lockout
// - local keeps settings, measures in free run
// - lockout in remote disables local, clear keys
// - clear key in remote triggers settled cycle
// - llo while local arms lockout for remote
// - lockout leaves on clear, ren, power, cable
// - ren false gives local, clears lockout
// - take-control messages are ignored
// - srq may assert in local or remote
// - serial poll or clear withdraws srq
// - program code errors raise srq without enable, except during a serial poll
// - data ready means result waiting to send
// - invalid program string flags code error
// - repeated failed attempts become retry error
// - any displayed error is instrument error
// - condition setting picks srq sources, panel or bus
// - clear leaves only code errors raising srq
// - clear resets byte, lockout, trigger, display
// - status byte bit layout fixed
// - sent status byte cleared on release events
// - ifc unaddresses and stops talk and listen
module grs_remote_ctrl (
  input wire logic hclk, // bus and core clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  input wire logic ren_pin, // remote enable line, high = true
  input wire logic ifc_pin, // interface clear line, high = true
  input wire logic cable_pin, // bus cable present
  input wire logic key_local_pin, // front-panel local key
  input wire logic key_clear_pin, // front-panel clear key
  input wire logic msg_mla, // my listen address pulse
  input wire logic msg_mta, // my talk address pulse
  input wire logic msg_ota, // other talk address pulse
  input wire logic msg_unl, // unlisten pulse
  input wire logic msg_unt, // untalk pulse
  input wire logic msg_gtl, // go to local pulse
  input wire logic msg_llo, // local lockout pulse
  input wire logic msg_sdc, // selected device clear pulse
  input wire logic msg_dcl, // device clear pulse
  input wire logic msg_spe, // serial poll enable pulse
  input wire logic msg_spd, // serial poll disable pulse
  input wire logic msg_tct, // take control pulse
  input wire logic sbyte_sent, // status byte handed over pulse
  input wire logic data_avail, // result waiting to be read
  input wire logic prog_bad, // invalid program string pulse
  input wire logic meas_fail, // failed attempt pulse
  input wire logic meas_done, // good measurement pulse
  input wire logic panel_srq_we, // panel writes srq condition
  input wire logic [1:0] panel_srq_val, // panel srq condition bits
  output logic remote_led, // remote indicator
  output logic addressed_led, // addressed indicator
  output logic srq_o, // srq line drive level
  output logic srq_oe, // srq line drive enable
  output logic [7:0] status_byte, // byte for serial poll
  output logic [1:0] trig_mode, // effective trigger mode
  output logic trig_settle, // start settled cycle pulse
  output logic read_right // right display selected
);
  grs_sb_if sb ();
  logic [`GRS_SYNC_N-1:0] pin_raw;
  logic [`GRS_SYNC_N-1:0] sync1_reg;
  logic [`GRS_SYNC_N-1:0] sync2_reg;
  logic key_local_d_reg;
  logic key_clear_d_reg;
  logic ren_s;
  logic ifc_s;
  logic cable_s;
  logic key_local_hit;
  logic key_clear_hit;
  grs_pkg::grs_rl_t rl_reg;
  logic lockout_reg;
  logic listen_reg;
  logic talk_reg;
  logic spoll_reg;
  logic clear_msg;
  logic go_remote;
  logic go_local;
  logic drop_link;
  logic panel_enabled;
  logic en_drdy_reg;
  logic en_ierr_reg;
  logic [1:0] trig_reg;
  logic rd_right_reg;
  logic [7:0] err_code_reg;
  logic [7:0] fail_cnt_reg;
  logic trig_settle_reg;
  logic wr_pend_reg;
  logic [`GRS_OFS_W-1:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic addr_ok;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  // every pin passes two flops before any logic reads it
  assign pin_raw = {key_clear_pin, key_local_pin, cable_pin, ifc_pin, ren_pin};
  genvar gi;
  generate
    for (gi = 0; gi < `GRS_SYNC_N; gi = gi + 1) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  assign ren_s = sync2_reg[0];
  assign ifc_s = sync2_reg[1];
  assign cable_s = sync2_reg[2];

  // key edges taken from the second stage only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_local_d_reg <= 1'b0;
      key_clear_d_reg <= 1'b0;
    end else begin
      key_local_d_reg <= sync2_reg[3];
      key_clear_d_reg <= sync2_reg[4];
    end
  end
  assign key_local_hit = sync2_reg[3] && !key_local_d_reg;
  assign key_clear_hit = sync2_reg[4] && !key_clear_d_reg;

  // message decode; msg_tct is left unread since this end never controls
  assign clear_msg = msg_dcl || (msg_sdc && listen_reg);
  assign drop_link = !ren_s || !cable_s;
  assign go_remote = msg_mla && ren_s && (rl_reg == grs_pkg::GRS_LOCAL);
  // keys only count in remote without lockout
  assign panel_enabled = (rl_reg == grs_pkg::GRS_REMOTE) && !lockout_reg;
  assign go_local = (msg_gtl && listen_reg) || (key_local_hit && panel_enabled);

  // remote/local state; ren false and cable loss override everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rl_reg <= grs_pkg::GRS_LOCAL;
    end else if (drop_link) begin
      rl_reg <= grs_pkg::GRS_LOCAL;
    end else if (go_remote) begin
      rl_reg <= grs_pkg::GRS_REMOTE;
    end else if (go_local && rl_reg == grs_pkg::GRS_REMOTE) begin
      rl_reg <= grs_pkg::GRS_LOCAL;
    end
  end

  // lockout flag survives gtl so it re-engages on the next remote entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lockout_reg <= 1'b0;
    end else if (msg_llo && !drop_link) begin
      lockout_reg <= 1'b1;
    end else if (drop_link || clear_msg) begin
      lockout_reg <= 1'b0;
    end
  end

  // listener and talker addressing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      listen_reg <= 1'b0;
      talk_reg <= 1'b0;
    end else if (ifc_s || !cable_s) begin
      listen_reg <= 1'b0;
      talk_reg <= 1'b0;
    end else begin
      if (msg_mla) begin
        listen_reg <= 1'b1;
      end else if (msg_unl) begin
        listen_reg <= 1'b0;
      end
      if (msg_mta) begin
        talk_reg <= 1'b1;
      end else if (msg_unt || msg_ota) begin
        talk_reg <= 1'b0;
      end
    end
  end

  // serial poll mode, ended by spd or abort
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spoll_reg <= 1'b0;
    end else if (msg_spd || ifc_s) begin
      spoll_reg <= 1'b0;
    end else if (msg_spe) begin
      spoll_reg <= 1'b1;
    end
  end

  // clear key starts one settled cycle only in unlocked remote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_settle_reg <= 1'b0;
    end else begin
      trig_settle_reg <= key_clear_hit && panel_enabled;
    end
  end

  // retry counter: at the limit the transient indication becomes an error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_cnt_reg <= 8'h00;
    end else if (meas_done) begin
      fail_cnt_reg <= 8'h00;
    end else if (meas_fail && fail_cnt_reg != `GRS_RETRY_LIMIT) begin
      fail_cnt_reg <= fail_cnt_reg + 8'h01;
    end
  end

  // bus write decode, data phase follows a one-cycle address phase
  assign addr_ok = (haddr[`GRS_OFS_W-1:0] == `GRS_CTRL_OFS) || (haddr[`GRS_OFS_W-1:0] == `GRS_STAT_OFS) ||
    (haddr[`GRS_OFS_W-1:0] == `GRS_ERR_OFS);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr[`GRS_OFS_W-1:0];
    end
  end

  // displayed error code; code error has priority over retry error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_code_reg <= 8'h00;
    end else if (prog_bad) begin
      err_code_reg <= `GRS_ERR_PROG_CODE;
    end else if (meas_fail && fail_cnt_reg == `GRS_RETRY_LIMIT - 8'h01) begin
      err_code_reg <= `GRS_ERR_RETRY;
    end else if (wr_pend_reg && wr_addr_reg == `GRS_ERR_OFS) begin
      err_code_reg <= hwdata[7:0];
    end
  end

  // srq condition enables; clear wins, then panel, then bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_drdy_reg <= 1'(`GRS_CTRL_RST >> `GRS_CTRL_EN_DRDY);
      en_ierr_reg <= 1'b0;
    end else if (clear_msg) begin
      en_drdy_reg <= 1'b0;
      en_ierr_reg <= 1'b0;
    end else if (panel_srq_we) begin
      en_drdy_reg <= panel_srq_val[0];
      en_ierr_reg <= panel_srq_val[1];
    end else if (wr_pend_reg && wr_addr_reg == `GRS_CTRL_OFS) begin
      en_drdy_reg <= hwdata[`GRS_CTRL_EN_DRDY];
      en_ierr_reg <= hwdata[`GRS_CTRL_EN_IERR];
    end
  end

  // trigger mode: forced to free run on remote entry and clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_reg <= grs_pkg::GRS_TRIG_FREE;
    end else if (clear_msg || go_remote) begin
      trig_reg <= grs_pkg::GRS_TRIG_FREE;
    end else if (wr_pend_reg && wr_addr_reg == `GRS_CTRL_OFS) begin
      trig_reg <= hwdata[`GRS_CTRL_TRIG_HI:`GRS_CTRL_TRIG_LO];
    end
  end

  // display selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_right_reg <= 1'b1;
    end else if (clear_msg) begin
      rd_right_reg <= 1'b1;
    end else if (wr_pend_reg && wr_addr_reg == `GRS_CTRL_OFS) begin
      rd_right_reg <= hwdata[`GRS_CTRL_RD_RIGHT];
    end
  end

  // conditions toward the status byte unit
  assign sb.data_ready = data_avail;
  assign sb.instr_err = (err_code_reg != 8'h00);
  assign sb.code_err = prog_bad;
  assign sb.en_drdy = en_drdy_reg;
  assign sb.en_ierr = en_ierr_reg;
  assign sb.spoll = msg_spe || spoll_reg;
  assign sb.sb_sent = sbyte_sent;
  assign sb.sb_release = msg_spd || ifc_s || msg_unt || msg_ota;
  assign sb.clear_msg = clear_msg;

  grs_status_unit u_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .sb(sb)
  );

  // read words
  assign ctrl_word = {27'h0, rd_right_reg, trig_reg, en_ierr_reg, en_drdy_reg};
  assign stat_word = {16'h0, sb.sbyte, 2'h0, sb.srq, spoll_reg, talk_reg, listen_reg, lockout_reg, rl_reg};

  // read data registered in the address phase; unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite && addr_ok) begin
      unique case (haddr[`GRS_OFS_W-1:0])
        `GRS_CTRL_OFS: rdata_reg <= ctrl_word;
        `GRS_STAT_OFS: rdata_reg <= stat_word;
        default: rdata_reg <= {24'h0, err_code_reg};
      endcase
    end else if (hready) begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // outputs; local always measures in free run whatever was programmed
  assign remote_led = (rl_reg == grs_pkg::GRS_REMOTE);
  assign addressed_led = listen_reg || talk_reg;
  assign trig_mode = remote_led ? trig_reg : grs_pkg::GRS_TRIG_FREE;
  assign trig_settle = trig_settle_reg;
  assign read_right = rd_right_reg;
  assign status_byte = sb.sbyte;
  assign srq_o = 1'b0; // line is pulled low when driven
  assign srq_oe = sb.srq;
endmodule : grs_remote_ctrl

// *** core/grs_consts.svh ***
// constants for the remote/local and service request block
`ifndef GRS_CONSTS_SVH
`define GRS_CONSTS_SVH
// register byte offsets
`define GRS_CTRL_OFS 8'h00
`define GRS_STAT_OFS 8'h04
`define GRS_ERR_OFS 8'h08
`define GRS_OFS_W 8
// control register fields
`define GRS_CTRL_EN_DRDY 0
`define GRS_CTRL_EN_IERR 1
`define GRS_CTRL_TRIG_LO 2
`define GRS_CTRL_TRIG_HI 3
`define GRS_CTRL_RD_RIGHT 4
`define GRS_CTRL_RST 32'h0000_0010
// status register fields
`define GRS_STAT_REMOTE 0
`define GRS_STAT_LOCKOUT 1
`define GRS_STAT_LISTEN 2
`define GRS_STAT_TALK 3
`define GRS_STAT_SPOLL 4
`define GRS_STAT_SRQ 5
`define GRS_STAT_SB_LO 8
// status byte bit positions (weights 1, 2, 4, 64)
`define GRS_SB_DRDY 0
`define GRS_SB_CODE 1
`define GRS_SB_IERR 2
`define GRS_SB_RQS 6
// error display codes and retry limit
`define GRS_ERR_PROG_CODE 8'h18
`define GRS_ERR_RETRY 8'h1f
`define GRS_RETRY_LIMIT 8'h80
`define GRS_SYNC_N 5
`endif

// *** core/grs_pkg.sv ***
// types shared by the remote/local and service request block
package grs_pkg;
  typedef enum logic [1:0] {
    GRS_TRIG_FREE = 2'h0,
    GRS_TRIG_HOLD = 2'h1,
    GRS_TRIG_IMM = 2'h2,
    GRS_TRIG_SETTLE = 2'h3
  } grs_trig_t;
  typedef enum logic {
    GRS_LOCAL = 1'b0,
    GRS_REMOTE = 1'b1
  } grs_rl_t;
endpackage : grs_pkg

// *** core/grs_sb_if.sv ***
// carrier between the control core and the status byte unit
`timescale 1ns/1ps
interface grs_sb_if;
  logic data_ready;
  logic instr_err;
  logic code_err;
  logic en_drdy;
  logic en_ierr;
  logic spoll;
  logic sb_sent;
  logic sb_release;
  logic clear_msg;
  logic [7:0] sbyte;
  logic srq;
  modport core (output data_ready, instr_err, code_err, en_drdy, en_ierr, spoll, sb_sent,
    sb_release, clear_msg, input sbyte, srq);
  modport unit (input data_ready, instr_err, code_err, en_drdy, en_ierr, spoll, sb_sent,
    sb_release, clear_msg, output sbyte, srq);
endinterface : grs_sb_if

// *** core/grs_status_unit.sv ***
// status byte and service request line state
`timescale 1ns/1ps
`include "grs_consts.svh"
module grs_status_unit (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  grs_sb_if.unit sb // conditions in, status byte out
);
  logic [7:0] sbyte_reg;
  logic srq_reg;
  logic sent_reg;
  logic drdy_hit;
  logic ierr_hit;
  logic any_hit;

  // only enabled conditions touch the byte; code errors always do
  assign drdy_hit = sb.data_ready && sb.en_drdy;
  assign ierr_hit = sb.instr_err && sb.en_ierr;
  assign any_hit = drdy_hit || ierr_hit || sb.code_err;

  // status byte: frozen during serial poll, cleared on clear or release after send
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sbyte_reg <= 8'h00;
    end else if (sb.clear_msg) begin
      sbyte_reg <= 8'h00;
    end else if (sent_reg && sb.sb_release) begin
      sbyte_reg <= 8'h00;
    end else if (!sb.spoll && any_hit) begin
      sbyte_reg[`GRS_SB_DRDY] <= sbyte_reg[`GRS_SB_DRDY] | drdy_hit;
      sbyte_reg[`GRS_SB_CODE] <= sbyte_reg[`GRS_SB_CODE] | sb.code_err;
      sbyte_reg[`GRS_SB_IERR] <= sbyte_reg[`GRS_SB_IERR] | ierr_hit;
      sbyte_reg[`GRS_SB_RQS] <= 1'b1;
    end
  end

  // remembers that the byte went out so a later release clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sent_reg <= 1'b0;
    end else if (sb.sb_sent) begin
      sent_reg <= 1'b1;
    end else if (sb.clear_msg || sb.sb_release) begin
      sent_reg <= 1'b0;
    end
  end

  // srq withdrawn on poll start, before the byte can be driven; clear wins too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srq_reg <= 1'b0;
    end else if (sb.clear_msg || sb.spoll) begin
      srq_reg <= 1'b0;
    end else if (any_hit) begin
      srq_reg <= 1'b1;
    end
  end

  assign sb.sbyte = sbyte_reg;
  assign sb.srq = srq_reg;
endmodule : grs_status_unit

// *** verification/grs_props.sv ***
// assertion checker for the remote/local and service request block
`timescale 1ns/1ps
module grs_props (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic ren_pin, // remote enable line
  input wire logic msg_mla, // my listen address
  input wire logic msg_unl, // unlisten
  input wire logic msg_spe, // serial poll enable
  input wire logic msg_spd, // serial poll disable
  input wire logic msg_dcl, // device clear
  input wire logic prog_bad, // invalid program string
  input wire logic remote_led, // remote indicator
  input wire logic addressed_led, // addressed indicator
  input wire logic srq_oe, // srq drive enable
  input wire logic [7:0] status_byte, // poll byte
  input wire logic [1:0] trig_mode, // effective trigger mode
  input wire logic trig_settle // settled cycle pulse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic poll_q;
  // tracks the poll, since the byte is frozen inside it and a bad code cannot show there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) poll_q <= 1'b0;
    else if (msg_spe) poll_q <= 1'b1;
    else if (msg_spd) poll_q <= 1'b0;
  end
  // two sync stages plus the state edge, with one cycle of margin
  sequence ren_gone_s; !ren_pin [*5]; endsequence
  sequence code_seen_s; prog_bad && !poll_q && !msg_spe && !msg_dcl; endsequence
  sequence code_shown_s; srq_oe && status_byte[1] && status_byte[6]; endsequence
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  enter_on_mla_a: assert property ($rose(remote_led) |-> $past(msg_mla))
    else $error("remote entered without listen address");
  entry_free_a: assert property ($rose(remote_led) |-> trig_mode == 2'h0)
    else $error("trigger mode not free run on entry");
  local_free_a: assert property (!remote_led |-> trig_mode == 2'h0)
    else $error("trigger mode not free run in local");
  ren_local_a: assert property (ren_gone_s |-> !remote_led)
    else $error("still remote after ren low");
  mla_addr_a: assert property (msg_mla && !msg_unl |=> addressed_led)
    else $error("addressed indicator off after listen address");
  poll_drop_a: assert property (msg_spe |=> !srq_oe)
    else $error("srq kept after poll enable");
  clear_drop_a: assert property (msg_dcl |=> !srq_oe && status_byte == 8'h00)
    else $error("srq or byte kept after clear");
  code_srq_a: assert property (code_seen_s |-> ##[1:3] code_shown_s)
    else $error("bad program code did not raise srq");
  byte_layout_a: assert property (status_byte[7] == 1'b0 && status_byte[5:3] == 3'h0 &&
    status_byte[6] == |status_byte[2:0])
    else $error("status byte layout broken");
  settle_pulse_a: assert property (trig_settle |-> remote_led ##1 !trig_settle)
    else $error("settled cycle pulse wrong");
endmodule : grs_props
bind grs_remote_ctrl grs_props chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .ren_pin(ren_pin), .msg_mla(msg_mla), .msg_unl(msg_unl), .msg_spe(msg_spe), .msg_spd(msg_spd),
  .msg_dcl(msg_dcl), .prog_bad(prog_bad), .remote_led(remote_led), .addressed_led(addressed_led),
  .srq_oe(srq_oe), .status_byte(status_byte), .trig_mode(trig_mode), .trig_settle(trig_settle));

// *** verification/grs_ctl_model.sv ***
// behavioural bus controller issuing interface messages and control lines
`timescale 1ns/1ps
module grs_ctl_model (
  input wire logic hclk, // clock shared with the device
  output logic ren_pin, // remote enable line
  output logic ifc_pin, // interface clear line
  output logic cable_pin, // cable present
  output logic [11:0] msg // one-hot message pulses
);
  initial begin
    ren_pin = 1'b0;
    ifc_pin = 1'b0;
    cable_pin = 1'b1;
    msg = 12'h000;
  end
  // one message, one cycle wide, after a random idle gap so both quick and slow controllers are seen
  task automatic send(input int idx);
    repeat ($urandom_range(0, 2)) @(posedge hclk);
    @(posedge hclk);
    msg <= 12'h001 << idx;
    @(posedge hclk);
    msg <= 12'h000;
  endtask : send
  // ifc, cable and ren levels, held long enough to cross the synchroniser before addressing
  task automatic lines(input logic [2:0] v);
    @(posedge hclk);
    {ifc_pin, cable_pin, ren_pin} <= v;
    repeat (5) @(posedge hclk);
  endtask : lines
endmodule : grs_ctl_model

// *** verification/tb.sv ***
// self-checking bench for the remote/local and service request block
`timescale 1ns/1ps
`include "grs_consts.svh"
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ren_pin, ifc_pin, cable_pin;
  logic dav, remote_led, addressed_led, srq_o, srq_oe;
  logic trig_settle, read_right;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, trig_mode, psv, en, cnd, ky;
  logic [2:0] hsize;
  logic [7:0] status_byte, sb;
  logic [11:0] msg;
  logic [4:0] pul;
  int errors = 0;
  int checked = 0;
  int settles = 0;
  int s0;
  assign hready = hreadyout;
  grs_remote_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ren_pin(ren_pin), .ifc_pin(ifc_pin), .cable_pin(cable_pin), .key_local_pin(ky[0]),
    .key_clear_pin(ky[1]), .msg_mla(msg[0]), .msg_mta(msg[1]), .msg_ota(msg[2]), .msg_unl(msg[3]),
    .msg_unt(msg[4]), .msg_gtl(msg[5]), .msg_llo(msg[6]), .msg_sdc(msg[7]), .msg_dcl(msg[8]),
    .msg_spe(msg[9]), .msg_spd(msg[10]), .msg_tct(msg[11]), .sbyte_sent(pul[0]), .data_avail(dav),
    .prog_bad(pul[1]), .meas_fail(pul[2]), .meas_done(pul[3]), .panel_srq_we(pul[4]), .panel_srq_val(psv),
    .remote_led(remote_led), .addressed_led(addressed_led), .srq_o(srq_o), .srq_oe(srq_oe),
    .status_byte(status_byte), .trig_mode(trig_mode), .trig_settle(trig_settle), .read_right(read_right));
  grs_ctl_model ctl_u (.hclk(hclk), .ren_pin(ren_pin), .ifc_pin(ifc_pin), .cable_pin(cable_pin), .msg(msg));
  // count settled-cycle pulses so keys can be judged by their effect
  always @(posedge hclk) if (trig_settle === 1'b1) settles++;
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single word transfer; read data is taken at the edge closing the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic key(input logic clr);
    @(posedge hclk);
    ky <= 2'h1 << clr;
    repeat (4) @(posedge hclk);
    ky <= 2'h0;
    repeat (4) @(posedge hclk);
  endtask : key
  task automatic pulse(input int k);
    @(posedge hclk);
    pul <= 5'h1 << k;
    @(posedge hclk);
    pul <= 5'h0;
  endtask : pulse
  task automatic stat(input logic r, input logic l, input logic li, input logic sq, input logic [7:0] b);
    xfer(1'b0, `GRS_STAT_OFS, 32'h0);
    chk(rd, {16'h0, b, 2'h0, sq, 2'h0, li, l, r});
  endtask : stat
  // poll byte from enables and present conditions; a code error needs no enable
  function automatic logic [7:0] sb_exp(input logic [1:0] e, input logic dr, input logic ie, input logic ce);
    return {1'b0, (e[0] & dr) | (e[1] & ie) | ce, 3'h0, e[1] & ie, ce, e[0] & dr};
  endfunction : sb_exp
  initial begin
    #(30000 * 100);
    errors++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, dav, ky, pul} = 10'h0;
    {haddr, hwdata, htrans, psv} = 68'h0;
    hsize = 3'h2;
    void'($urandom(32'hbd7b));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    xfer(1'b0, `GRS_CTRL_OFS, 32'h0);
    chk(rd, `GRS_CTRL_RST);
    stat(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk(32'({remote_led, addressed_led, srq_oe, read_right}), 32'h1);
    xfer(1'b1, `GRS_CTRL_OFS, 32'h1c);
    chk(32'(trig_mode), 32'h0);
    ctl_u.lines(3'h3);
    chk(32'(remote_led), 32'h0);
    ctl_u.send(0);
    repeat (2) @(posedge hclk);
    chk(32'({remote_led, addressed_led, trig_mode}), 32'hc);
    xfer(1'b0, `GRS_CTRL_OFS, 32'h0);
    chk(rd, 32'h10);
    xfer(1'b1, `GRS_CTRL_OFS, 32'h18);
    ctl_u.send(11);
    stat(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
    s0 = settles;
    key(1'b1);
    chk(settles - s0, 1);
    ctl_u.send(6);
    key(1'b0);
    key(1'b1);
    chk(settles - s0, 1);
    stat(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
    ctl_u.send(5);
    repeat (2) @(posedge hclk);
    chk(32'({remote_led, addressed_led}), 32'h1);
    stat(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    ctl_u.send(0);
    key(1'b0);
    chk(32'(remote_led), 32'h1);
    ctl_u.lines(3'h2);
    stat(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    xfer(1'b0, `GRS_CTRL_OFS, 32'h0);
    chk(rd, 32'h10);
    ctl_u.lines(3'h3);
    ctl_u.send(6);
    repeat (2) @(posedge hclk);
    chk(32'(remote_led), 32'h0);
    ctl_u.send(0);
    key(1'b0);
    stat(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
    // cable loss or ren false, drawn at random; only cable loss drops the listener
    cnd = 2'($urandom_range(1, 2));
    ctl_u.lines({1'b0, cnd});
    stat(1'b0, 1'b0, cnd[1], 1'b0, 8'h00);
    ctl_u.lines(3'h3);
    ctl_u.send(0);
    ctl_u.send(1);
    ctl_u.lines(3'h7);
    ctl_u.lines(3'h3);
    chk(32'(addressed_led), 32'h0);
    ctl_u.lines(3'h2);
    ctl_u.send(0);
    // random enables and conditions in local as listener, set by bus and by panel in turn
    for (int i = 0; i < 8; i++) begin
      en = 2'($urandom_range(0, 3));
      cnd = 2'($urandom_range(0, 3));
      if (i % 2 == 1) begin
        psv <= en;
        pulse(4);
      end else xfer(1'b1, `GRS_CTRL_OFS, {27'h0, cnd[0], 2'h3, en});
      dav <= cnd[0];
      xfer(1'b1, `GRS_ERR_OFS, cnd[1] ? 32'(8'($urandom_range(1, 15))) : 32'h0);
      repeat (3) @(posedge hclk);
      sb = sb_exp(en, cnd[0], cnd[1], 1'b0);
      chk(32'(srq_oe), 32'(sb[6]));
      stat(1'b0, 1'b0, 1'b1, sb[6], sb);
      ctl_u.send(8 - i % 2);
      repeat (2) @(posedge hclk);
      chk(32'(read_right), 32'h1);
      xfer(1'b0, `GRS_CTRL_OFS, 32'h0);
      chk(rd, 32'h10);
      stat(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
      dav <= 1'b0;
      xfer(1'b1, `GRS_ERR_OFS, 32'h0);
    end
    pulse(1);
    repeat (4) @(posedge hclk);
    xfer(1'b0, `GRS_ERR_OFS, 32'h0);
    chk(rd, 32'(`GRS_ERR_PROG_CODE));
    chk(32'(status_byte), 32'(sb_exp(2'h0, 1'b0, 1'b1, 1'b1)));
    ctl_u.send(9);
    @(posedge hclk);
    chk(32'(srq_oe), 32'h0);
    ctl_u.send(1);
    pulse(0);
    ctl_u.send(10);
    repeat (2) @(posedge hclk);
    chk(32'({status_byte, srq_oe}), 32'h0);
    ctl_u.send(2);
    ctl_u.send(4);
    ctl_u.send(3);
    @(posedge hclk);
    chk(32'(addressed_led), 32'h0);
    xfer(1'b1, `GRS_ERR_OFS, 32'h0);
    ctl_u.send(8);
    xfer(1'b1, `GRS_CTRL_OFS, 32'h12);
    repeat (5) pulse(2);
    pulse(3);
    repeat (127) pulse(2);
    xfer(1'b0, `GRS_ERR_OFS, 32'h0);
    chk(rd, 32'h0);
    pulse(2);
    repeat (3) @(posedge hclk);
    xfer(1'b0, `GRS_ERR_OFS, 32'h0);
    chk(rd, 32'(`GRS_ERR_RETRY));
    chk(32'({status_byte, srq_oe}), {23'h0, sb_exp(2'h2, 1'b0, 1'b1, 1'b0), 1'b1});
    wrap_up();
  end
endmodule : tb
